// >>> bms_exec_regs.vh
// Register map, opcodes, flag positions and phase lengths of the block-move/search engine.
`ifndef BMS_EXEC_REGS_VH
`define BMS_EXEC_REGS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define BMS_REG_CTRL 8'h00
`define BMS_REG_SRC 8'h04
`define BMS_REG_TGT 8'h08
`define BMS_REG_CNT 8'h0C
`define BMS_REG_ACCF 8'h10
`define BMS_REG_PC 8'h14
`define BMS_REG_STATUS 8'h18

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define BMS_CTRL_OP_LO 0
`define BMS_CTRL_PFX_LO 8
`define BMS_CTRL_START 16

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define BMS_ST_BUSY 0
`define BMS_ST_BAD_OP 1
`define BMS_ST_INT_TAKEN 2
`define BMS_ST_TLAST_LO 8

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define BMS_OP_PREFIX 8'hED
`define BMS_OP_MOVE_DOWN_SINGLE 8'hA8
`define BMS_OP_MOVE_DOWN_REPEAT 8'hB8
`define BMS_OP_SEARCH_UP_SINGLE 8'hA1
`define BMS_OP_SEARCH_UP_REPEAT 8'hB1
`define BMS_OP_SEARCH_DOWN_SINGLE 8'hA9
`define BMS_OP_SEARCH_DOWN_REPEAT 8'hB9

// ----------------------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------------------
`define BMS_FLAG_NEG 7
`define BMS_FLAG_EQ 6
`define BMS_FLAG_NIB 4
`define BMS_FLAG_PV 2
`define BMS_FLAG_SUB 1
`define BMS_FLAG_CY 0

// ----------------------------------------------------------------------------
// Last clock-state count of each phase, refresh ticks and step constants (memory wait cycles add no clock state)
// ----------------------------------------------------------------------------
`define BMS_T_FETCH 3'h7
`define BMS_T_READ 3'h2
`define BMS_T_EXEC 3'h4
`define BMS_T_RPT 3'h4
`define BMS_RFSH_A 3'h1
`define BMS_RFSH_B 3'h3
`define BMS_PC_STEP 16'h0002
`define BMS_ONE16 16'h0001
`define BMS_ONE5 5'h01

`endif

// >>> bms_fifo.v
// Parameterised synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none

module bms_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire ref_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW:0] wr_ptr_q;
    reg [AW:0] rd_ptr_q;
    wire full;
    wire empty;
    wire push;
    wire pop;

    // The extra pointer bit separates full from empty without a counter.
    assign empty = (wr_ptr_q == rd_ptr_q);
    assign full = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && (wr_ptr_q[AW] != rd_ptr_q[AW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;
    assign out_data = mem_q[rd_ptr_q[AW-1:0]];

    always @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule
`default_nettype wire

// >>> bms_block_exec.v
// Execution engine for the decrementing block moves and the block searches.
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "bms_exec_regs.vh"

// Function
// - ED A8 copies source byte to target, decrements all three pairs, 16 states.
// - Single move keeps S, Z, C; clears H, N; PV set when counter nonzero.
// - ED B8 repeats the move, rewinding PC by two while counter nonzero.
// - Repeats accept interrupts between iterations and run two refresh cycles.
// - A repeat move started with a zero counter runs through 64 Kbytes.
// - Repeat move termination clears H, PV and N; keeps S and Z.
// - ED A1 compares accumulator with source byte, source up, counter down.
// - Compare sets S from sign, Z on match, H on nibble borrow, N; keeps C.
// - Compare sets PV when decremented counter is nonzero, clears it otherwise.
// - Compare leaves accumulator and memory alone; only pointer, counter, flags and PC change.
// - ED B1 repeats the upward compare until match or zero counter.
// - ED A9 compares with source byte, decrementing source and counter, 16 states.
// - ED B9 repeats the downward compare until match or zero counter.
// - A repeat compare started with zero counter searches 64 Kbytes if unmatched.
module bms_block_exec (
    input wire ref_clk,
    input wire rst_n,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg [15:0] mem_addr_q,
    output reg mem_rd_q,
    output reg mem_wr_q,
    output reg [7:0] mem_wdata_q,
    input wire [7:0] mem_rdata,
    input wire mem_ack,
    input wire irq_pin,
    output reg irq_ack_q,
    output reg rfsh_q
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_FETCH = 3'h1;
    localparam [2:0] ST_READ = 3'h2;
    localparam [2:0] ST_EXEC = 3'h3;
    localparam [2:0] ST_RPT = 3'h4;

    reg irq_meta_q;
    reg irq_sync_q;
    reg [15:0] src_q;
    reg [15:0] tgt_q;
    reg [15:0] cnt_q;
    reg [15:0] pc_q;
    reg [7:0] acc_q;
    reg [7:0] flags_q;
    reg [7:0] op_q;
    reg bad_op_q;
    reg int_taken_q;
    reg [4:0] tacc_q;
    reg [4:0] tlast_q;
    reg [2:0] state_q;
    reg [2:0] tcnt_q;
    reg rd_done_q;
    reg wr_done_q;
    reg [7:0] byte_q;
    reg [31:0] rdata_d;

    wire busy;
    wire req;
    wire wr_fire;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_pop;
    wire [7:0] fifo_out;
    wire is_move;
    wire is_repeat;
    wire is_up;
    wire op_ok;
    wire start;
    wire [15:0] cnt_dec;
    wire cnt_nz;
    wire match;
    wire [8:0] diff;
    wire nib_borrow;
    wire rpt_go;
    wire exec_end;
    wire [15:0] wr_lo;

    assign busy = (state_q != ST_IDLE);
    assign req = avs_read || avs_write;
    assign wr_fire = avs_write && !avs_waitrequest;
    assign wr_lo = avs_writedata[15:0];

    // ------------------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------------------
    assign is_move = (op_q == `BMS_OP_MOVE_DOWN_SINGLE) || (op_q == `BMS_OP_MOVE_DOWN_REPEAT);
    assign is_repeat = (op_q == `BMS_OP_MOVE_DOWN_REPEAT) ||
                       (op_q == `BMS_OP_SEARCH_UP_REPEAT) ||
                       (op_q == `BMS_OP_SEARCH_DOWN_REPEAT);
    assign is_up = (op_q == `BMS_OP_SEARCH_UP_SINGLE) || (op_q == `BMS_OP_SEARCH_UP_REPEAT);

    function op_valid;
        input [7:0] op;
        begin
            op_valid = (op == `BMS_OP_MOVE_DOWN_SINGLE) || (op == `BMS_OP_MOVE_DOWN_REPEAT) ||
                       (op == `BMS_OP_SEARCH_UP_SINGLE) || (op == `BMS_OP_SEARCH_UP_REPEAT) ||
                       (op == `BMS_OP_SEARCH_DOWN_SINGLE) ||
                       (op == `BMS_OP_SEARCH_DOWN_REPEAT);
        end
    endfunction

    assign op_ok = (avs_writedata[`BMS_CTRL_PFX_LO+7:`BMS_CTRL_PFX_LO] == `BMS_OP_PREFIX) &&
                   op_valid(avs_writedata[`BMS_CTRL_OP_LO+7:`BMS_CTRL_OP_LO]);
    assign start = wr_fire && (avs_address == `BMS_REG_CTRL) && !busy &&
                   avs_writedata[`BMS_CTRL_START] && avs_byteenable[2];

    // ------------------------------------------------------------------------
    // Step arithmetic
    // ------------------------------------------------------------------------
    assign cnt_dec = cnt_q - `BMS_ONE16;
    assign cnt_nz = (cnt_dec != 16'h0000);
    assign match = (acc_q == byte_q);
    assign diff = {1'b0, acc_q} - {1'b0, byte_q};
    assign nib_borrow = (acc_q[3:0] < byte_q[3:0]);
    // A zero counter decrements to FFFF, so a zero start runs the full 64 Kbytes.
    assign rpt_go = is_repeat && cnt_nz && (is_move || !match);
    assign exec_end = (state_q == ST_EXEC) && (tcnt_q == `BMS_T_EXEC) && (!is_move || wr_done_q);

    // ------------------------------------------------------------------------
    // Read data buffer
    // ------------------------------------------------------------------------
    assign fifo_pop = (state_q == ST_EXEC) && (tcnt_q == 3'h0) && fifo_out_valid;

    bms_fifo #(
        .WIDTH(8),
        .DEPTH(8),
        .AW(3)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(mem_rd_q && mem_ack),
        .in_ready(fifo_in_ready),
        .in_data(mem_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    // ------------------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------------------
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0] be;
        begin
            merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    always @* begin
        rdata_d = 32'h00000000;
        case (avs_address)
            `BMS_REG_CTRL: rdata_d = {24'h000000, op_q};
            `BMS_REG_SRC: rdata_d = {16'h0000, src_q};
            `BMS_REG_TGT: rdata_d = {16'h0000, tgt_q};
            `BMS_REG_CNT: rdata_d = {16'h0000, cnt_q};
            `BMS_REG_ACCF: rdata_d = {16'h0000, flags_q, acc_q};
            `BMS_REG_PC: rdata_d = {16'h0000, pc_q};
            `BMS_REG_STATUS: rdata_d = {19'h00000, tlast_q, 5'h00, int_taken_q, bad_op_q, busy};
            default: rdata_d = 32'h00000000;
        endcase
    end

    // Every access sees one wait cycle, so the answer comes from registers.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rdata_d;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt pin synchroniser
    // ------------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_meta_q <= 1'b0;
            irq_sync_q <= 1'b0;
        end else begin
            irq_meta_q <= irq_pin;
            irq_sync_q <= irq_meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer and register file
    // ------------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            tcnt_q <= 3'h0;
            tacc_q <= 5'h00;
            tlast_q <= 5'h00;
            src_q <= 16'h0000;
            tgt_q <= 16'h0000;
            cnt_q <= 16'h0000;
            pc_q <= 16'h0000;
            acc_q <= 8'h00;
            flags_q <= 8'h00;
            op_q <= 8'h00;
            bad_op_q <= 1'b0;
            int_taken_q <= 1'b0;
            rd_done_q <= 1'b0;
            wr_done_q <= 1'b0;
            byte_q <= 8'h00;
            mem_addr_q <= 16'h0000;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_wdata_q <= 8'h00;
            irq_ack_q <= 1'b0;
            rfsh_q <= 1'b0;
        end else begin
            irq_ack_q <= 1'b0;
            rfsh_q <= 1'b0;
            // Software clears sticky status by writing ones; a same-cycle set wins below.
            if (wr_fire && avs_address == `BMS_REG_STATUS && avs_byteenable[0]) begin
                if (avs_writedata[`BMS_ST_BAD_OP]) begin
                    bad_op_q <= 1'b0;
                end
                if (avs_writedata[`BMS_ST_INT_TAKEN]) begin
                    int_taken_q <= 1'b0;
                end
            end
            // The register file is only writable while the engine is idle.
            if (wr_fire && !busy) begin
                case (avs_address)
                    `BMS_REG_SRC: src_q <= merge16(src_q, wr_lo, avs_byteenable[1:0]);
                    `BMS_REG_TGT: tgt_q <= merge16(tgt_q, wr_lo, avs_byteenable[1:0]);
                    `BMS_REG_CNT: cnt_q <= merge16(cnt_q, wr_lo, avs_byteenable[1:0]);
                    `BMS_REG_PC: pc_q <= merge16(pc_q, wr_lo, avs_byteenable[1:0]);
                    `BMS_REG_ACCF: begin
                        if (avs_byteenable[0]) begin
                            acc_q <= avs_writedata[7:0];
                        end
                        if (avs_byteenable[1]) begin
                            flags_q <= avs_writedata[15:8];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (mem_rd_q && mem_ack) begin
                mem_rd_q <= 1'b0;
                rd_done_q <= 1'b1;
            end
            if (mem_wr_q && mem_ack) begin
                mem_wr_q <= 1'b0;
                wr_done_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        if (op_ok) begin
                            op_q <= avs_writedata[`BMS_CTRL_OP_LO+7:`BMS_CTRL_OP_LO];
                            state_q <= ST_FETCH;
                            tcnt_q <= 3'h0;
                            tacc_q <= 5'h00;
                        end else begin
                            bad_op_q <= 1'b1;
                        end
                    end
                end
                ST_FETCH: begin
                    tacc_q <= tacc_q + `BMS_ONE5;
                    if (tcnt_q == `BMS_T_FETCH) begin
                        pc_q <= pc_q + `BMS_PC_STEP;
                        state_q <= ST_READ;
                        tcnt_q <= 3'h0;
                        rd_done_q <= 1'b0;
                    end else begin
                        tcnt_q <= tcnt_q + 3'h1;
                    end
                end
                ST_READ: begin
                    // No read is launched while the buffer is full, so data is never dropped.
                    if (tcnt_q == 3'h0 && !mem_rd_q && !rd_done_q && fifo_in_ready) begin
                        mem_rd_q <= 1'b1;
                        mem_addr_q <= src_q;
                    end
                    if (tcnt_q != `BMS_T_READ) begin
                        if (tcnt_q != 3'h0 || mem_rd_q || rd_done_q) begin
                            tcnt_q <= tcnt_q + 3'h1;
                            tacc_q <= tacc_q + `BMS_ONE5;
                        end
                    end else if (rd_done_q || (mem_rd_q && mem_ack)) begin
                        tacc_q <= tacc_q + `BMS_ONE5;
                        state_q <= ST_EXEC;
                        tcnt_q <= 3'h0;
                        wr_done_q <= 1'b0;
                    end
                end
                ST_EXEC: begin
                    if (tcnt_q == 3'h0) begin
                        if (fifo_out_valid) begin
                            byte_q <= fifo_out;
                            tcnt_q <= 3'h1;
                            tacc_q <= tacc_q + `BMS_ONE5;
                        end
                    end else if (tcnt_q != `BMS_T_EXEC) begin
                        if (tcnt_q == 3'h1 && is_move) begin
                            mem_wr_q <= 1'b1;
                            mem_addr_q <= tgt_q;
                            mem_wdata_q <= byte_q;
                        end
                        tcnt_q <= tcnt_q + 3'h1;
                        tacc_q <= tacc_q + `BMS_ONE5;
                    end else if (exec_end) begin
                        cnt_q <= cnt_dec;
                        if (is_move) begin
                            src_q <= src_q - `BMS_ONE16;
                            tgt_q <= tgt_q - `BMS_ONE16;
                            flags_q[`BMS_FLAG_NIB] <= 1'b0;
                            flags_q[`BMS_FLAG_SUB] <= 1'b0;
                            flags_q[`BMS_FLAG_PV] <= cnt_nz;
                        end else begin
                            // Accumulator and memory stay untouched on a search.
                            if (is_up) begin
                                src_q <= src_q + `BMS_ONE16;
                            end else begin
                                src_q <= src_q - `BMS_ONE16;
                            end
                            flags_q[`BMS_FLAG_NEG] <= diff[7];
                            flags_q[`BMS_FLAG_EQ] <= match;
                            flags_q[`BMS_FLAG_NIB] <= nib_borrow;
                            flags_q[`BMS_FLAG_SUB] <= 1'b1;
                            flags_q[`BMS_FLAG_PV] <= cnt_nz;
                        end
                        tacc_q <= tacc_q + `BMS_ONE5;
                        tcnt_q <= 3'h0;
                        if (rpt_go) begin
                            pc_q <= pc_q - `BMS_PC_STEP;
                            state_q <= ST_RPT;
                        end else begin
                            tlast_q <= tacc_q + `BMS_ONE5;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_RPT: begin
                    if (tcnt_q == `BMS_RFSH_A || tcnt_q == `BMS_RFSH_B) begin
                        rfsh_q <= 1'b1;
                    end
                    if (tcnt_q == `BMS_T_RPT) begin
                        tlast_q <= tacc_q + `BMS_ONE5;
                        tacc_q <= 5'h00;
                        tcnt_q <= 3'h0;
                        // PC already points back at the instruction, so a taken
                        // interrupt returns to it and the loop resumes on restart.
                        if (irq_sync_q) begin
                            irq_ack_q <= 1'b1;
                            int_taken_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_FETCH;
                        end
                    end else begin
                        tcnt_q <= tcnt_q + 3'h1;
                        tacc_q <= tacc_q + `BMS_ONE5;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    tcnt_q <= 3'h0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> bms_exec_asserts.sv
// Concurrent checks on the engine's register bus and memory link.
`timescale 1ns/10ps
`default_nettype none
module bms_exec_asserts (
    input wire ref_clk,
    input wire rst_n,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire [15:0] mem_addr_q,
    input wire mem_rd_q,
    input wire mem_wr_q,
    input wire mem_ack,
    input wire irq_ack_q,
    input wire rfsh_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rfsh_tail;
        !rfsh_q ##1 rfsh_q ##1 !rfsh_q;
    endsequence
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus access not answered after one wait");
    a_bus_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_mem_rd_hold: assert property (mem_rd_q && !mem_ack
        |=> mem_rd_q && $stable(mem_addr_q)) else $error("memory read dropped before ack");
    a_mem_rd_drop: assert property (mem_rd_q && mem_ack |=> !mem_rd_q)
        else $error("memory read held after ack");
    a_mem_wr_hold: assert property (mem_wr_q && !mem_ack
        |=> mem_wr_q && $stable(mem_addr_q)) else $error("memory write dropped before ack");
    a_mem_no_both: assert property (!(mem_rd_q && mem_wr_q))
        else $error("memory read and write together");
    a_rfsh_two_pulses: assert property (rfsh_q && !$past(rfsh_q, 2) |=> s_rfsh_tail)
        else $error("refresh pulses not paired");
    a_irq_between_steps: assert property (irq_ack_q
        |-> !mem_rd_q && !mem_wr_q ##1 !irq_ack_q)
        else $error("interrupt taken inside a transfer");
endmodule
bind bms_block_exec bms_exec_asserts u_chk (.ref_clk, .rst_n, .avs_read, .avs_write,
    .avs_waitrequest, .mem_addr_q, .mem_rd_q, .mem_wr_q, .mem_ack, .irq_ack_q, .rfsh_q);
`default_nettype wire

// >>> bms_mem_model.sv
// Byte-wide memory standing on the far side of the engine's memory link.
`timescale 1ns/10ps
`default_nettype none
module bms_mem_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic [15:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic ack
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_q;
    // The data bus scrambles outside an ack so a stale byte never passes as fresh.
    always @(posedge ref_clk) begin
        ack <= 1'b0;
        if (!rst_n) begin
            wait_q <= 2'h0;
            rdata <= 8'h5A;
        end else if ((rd || wr) && !ack && (!slow || wait_q == 2'h3)) begin
            ack <= 1'b1;
            wait_q <= 2'h0;
            if (wr)
                mem[addr] <= wdata;
            else
                rdata <= mem[addr];
        end else if (!ack) begin
            wait_q <= (rd || wr) ? wait_q + 2'h1 : 2'h0;
            rdata <= ~rdata;
        end
    end
endmodule
`default_nettype wire

// >>> tb_block_move_search_exec.sv
// Self-checking bench for the block-move and search engine.
`timescale 1ns/10ps
`default_nettype none
`include "bms_exec_regs.vh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_block_move_search_exec;
    logic ref_clk = 0;
    logic rst_n = 0;
    logic [7:0] avs_address = 0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = 0;
    logic irq_pin = 0;
    logic slow = 0;
    logic [31:0] rd;
    wire [31:0] avs_readdata;
    wire [15:0] mem_addr_q;
    wire [7:0] mem_wdata_q, mem_rdata;
    wire avs_waitrequest, mem_rd_q, mem_wr_q, mem_ack, irq_ack_q, rfsh_q;
    int bad_count = 0;
    int checks_done = 0;
    int rf = 0;
    int ac = 0;
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        rf += (rfsh_q === 1'b1);
        ac += (irq_ack_q === 1'b1);
    end
    bms_block_exec dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .mem_addr_q, .mem_rd_q,
        .mem_wr_q, .mem_wdata_q, .mem_rdata, .mem_ack, .irq_pin, .irq_ack_q, .rfsh_q);
    bms_mem_model mem_u (.ref_clk, .rst_n, .slow, .addr(mem_addr_q), .rd(mem_rd_q),
        .wr(mem_wr_q), .wdata(mem_wdata_q), .rdata(mem_rdata), .ack(mem_ack));
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task set(input logic [15:0] s, t, c, input logic [7:0] acc, fl);
        bus(1, `BMS_REG_SRC, {16'h0, s});
        bus(1, `BMS_REG_TGT, {16'h0, t});
        bus(1, `BMS_REG_CNT, {16'h0, c});
        bus(1, `BMS_REG_ACCF, {16'h0, fl, acc});
        bus(1, `BMS_REG_PC, 32'h0100);
        rf = 0;
        ac = 0;
    endtask
    task run(input logic [7:0] op);
        bus(1, `BMS_REG_CTRL, {15'h0, 1'b1, `BMS_OP_PREFIX, op});
        do bus(0, `BMS_REG_STATUS, 0); while (rd[`BMS_ST_BUSY] !== 1'b0);
    endtask
    task regs(input logic [15:0] s, t, c, af, pc, input logic [4:0] tl);
        bus(0, `BMS_REG_SRC, 0);
        `CHK("source", s, rd[15:0])
        bus(0, `BMS_REG_TGT, 0);
        `CHK("target", t, rd[15:0])
        bus(0, `BMS_REG_CNT, 0);
        `CHK("count", c, rd[15:0])
        bus(0, `BMS_REG_ACCF, 0);
        `CHK("acc_flags", af, rd[15:0])
        bus(0, `BMS_REG_PC, 0);
        `CHK("pc", pc, rd[15:0])
        bus(0, `BMS_REG_STATUS, 0);
        `CHK("states", tl, rd[12:8])
    endtask
    task t_move;
        mem_u.mem[16'h1111] = 8'h88;
        set(16'h1111, 16'h2222, 16'h0007, 8'h00, 8'hD7);
        run(`BMS_OP_MOVE_DOWN_SINGLE);
        regs(16'h1110, 16'h2221, 16'h0006, 16'hC500, 16'h0102, 5'h10);
        `CHK("moved byte", 8'h88, mem_u.mem[16'h2222])
        mem_u.mem[16'h1112] = 8'h88;
        mem_u.mem[16'h1113] = 8'h36;
        mem_u.mem[16'h1114] = 8'hA5;
        slow <= 1;
        set(16'h1114, 16'h2225, 16'h0003, 8'h00, 8'hD7);
        run(`BMS_OP_MOVE_DOWN_REPEAT);
        slow <= 0;
        regs(16'h1111, 16'h2222, 16'h0000, 16'hC100, 16'h0102, 5'h10);
        `CHK("block", 24'h8836A5, {mem_u.mem[16'h2223], mem_u.mem[16'h2224],
            mem_u.mem[16'h2225]})
        `CHK("refresh", 4, rf)
        $display("test move done");
    endtask
    task t_irq;
        // A zero count would run 64K steps, so an interrupt cuts it after the first one.
        set(16'h0000, 16'h8000, 16'h0000, 8'h00, 8'h00);
        irq_pin <= 1;
        run(`BMS_OP_MOVE_DOWN_REPEAT);
        irq_pin <= 0;
        regs(16'hFFFF, 16'h7FFF, 16'hFFFF, 16'h0400, 16'h0100, 5'h15);
        `CHK("int taken", 1'b1, rd[`BMS_ST_INT_TAKEN])
        `CHK("acks", 1, ac)
        bus(1, `BMS_REG_STATUS, 32'h4);
        bus(0, `BMS_REG_STATUS, 0);
        `CHK("int cleared", 1'b0, rd[`BMS_ST_INT_TAKEN])
        $display("test irq done");
    endtask
    task t_search;
        for (int i = 0; i < 4; i++) begin
            mem_u.mem[16'h1111] = i[1] ? 8'h21 : 8'h3B;
            set(16'h1111, 16'h0, i[1] ? 16'h2 : 16'h1, i[1] ? 8'h10 : 8'h3B, {7'h0, !i[1]});
            run(i[0] ? `BMS_OP_SEARCH_DOWN_SINGLE : `BMS_OP_SEARCH_UP_SINGLE);
            regs(i[0] ? 16'h1110 : 16'h1112, 16'h0, {15'h0, i[1]}, i[1] ? 16'h9610 : 16'h433B,
                16'h0102, 5'h10);
            `CHK("memory kept", i[1] ? 8'h21 : 8'h3B, mem_u.mem[16'h1111])
        end
        for (int i = 0; i < 2; i++) begin
            mem_u.mem[i ? 16'h1118 : 16'h1111] = 8'h52;
            mem_u.mem[i ? 16'h1117 : 16'h1112] = 8'h00;
            mem_u.mem[i ? 16'h1116 : 16'h1113] = 8'hF3;
            set(i ? 16'h1118 : 16'h1111, 16'h0, i ? 16'h0 : 16'h7, 8'hF3, 8'h00);
            run(i ? `BMS_OP_SEARCH_DOWN_REPEAT : `BMS_OP_SEARCH_UP_REPEAT);
            regs(i ? 16'h1115 : 16'h1114, 16'h0, i ? 16'hFFFD : 16'h4, 16'h46F3, 16'h0102,
                5'h10);
            `CHK("refresh", 4, rf)
        end
        $display("test search done");
    endtask
    task t_misc;
        bus(1, `BMS_REG_CTRL, {15'h0, 1'b1, `BMS_OP_PREFIX, 8'h00});
        bus(0, `BMS_REG_STATUS, 0);
        `CHK("bad opcode", 2'h2, rd[1:0])
        bus(0, 8'h1C, 0);
        `CHK("unmapped", 32'h0, rd)
        $display("test misc done");
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1;
        t_move;
        t_irq;
        t_search;
        t_misc;
        tally_and_finish;
    end
    initial begin
        repeat (50000) @(posedge ref_clk);
        bad_count++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
